// ### design/sepfe_top.sv
// Serial memory client: pin sampling, device select, byte engine and array.
`timescale 1ns/1ps
// Functional notes
// R1: Write-protect high blocks every array write.
// R2: Write-protect low lets writes proceed normally.
// R3: Undriven straps and write-protect read as low.
// R4: Respond only when sent address bits match the straps; else ignore.
// R5: Small variant matches both strap inputs.
// R6: Large variant matches only the upper strap.
// R7: Large variant ignores the lower strap entirely.
// R8: Data bits are sampled at the clock line's rising edge.
// R9: Output data changes only after a clock falling edge.
// R10: Data line is open drain: pull low or release, never drive high.
// R11: Host keeps the clock line high while the bus idles.
// R12: Array holds 512 or 1024 bytes of 8 bits.
module sepfe_top #(
	parameter int         DEPTH    = sepfe_pkg::DEPTH_SMALL,
	parameter logic [3:0] DEV_TYPE = 4'hA
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Serial bus
	input  wire logic scl_pin,
	input  wire logic sda_in,
	output logic      sda_o,
	output logic      sda_oe_n,
	// Straps
	input  wire logic wp_pin,
	input  wire logic chip_select_strap_low,
	input  wire logic chip_select_strap_high,
	// Status
	output logic      selected
);
	localparam int AW     = $clog2(DEPTH);
	localparam bit LARGE  = (DEPTH == sepfe_pkg::DEPTH_LARGE);

	// R12 array size
	if (DEPTH != sepfe_pkg::DEPTH_SMALL && DEPTH != sepfe_pkg::DEPTH_LARGE) begin : g_bad_depth
		$error("DEPTH must be 512 or 1024");
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic       wp_lvl;
	logic       low_lvl;
	logic       high_lvl;
	logic [4:0] sync_q;
	logic       scl_low_s;
	logic       sda_low_s;
	logic       scl_s;
	logic       sda_s;
	logic       wp_s;
	logic       strap_low_s;
	logic       strap_high_s;

	// R3 floating is low
	// Only a clear high counts; a floating pad reads as low, as its pull-down would make it.
	assign wp_lvl   = (wp_pin === 1'b1);
	assign low_lvl  = (chip_select_strap_low === 1'b1);
	assign high_lvl = (chip_select_strap_high === 1'b1);

	sepfe_sync #(.W(5)) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({~scl_pin, ~sda_in, wp_lvl, low_lvl, high_lvl}),
		.q    (sync_q)
	);

	// The bus lines pass inverted so that the cleared flops read as an idle high bus.
	// Without this a reset would leave a false clock fall and rise behind it.
	assign {scl_low_s, sda_low_s, wp_s, strap_low_s, strap_high_s} = sync_q;
	assign scl_s = ~scl_low_s;
	assign sda_s = ~sda_low_s;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Bus event detection

	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_ff @(posedge clk) begin
		if (srst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Byte engine

	sepfe_mem_if #(.AW(AW)) mif ();

	sepfe_pkg::sepfe_state_e state_reg;
	sepfe_pkg::sepfe_state_e state_next;
	logic [3:0]              bitcnt_reg;
	logic [3:0]              bitcnt_next;
	logic [7:0]              shift_reg;
	logic [7:0]              shift_next;
	logic [7:0]              out_reg;
	logic [7:0]              out_next;
	logic [AW-1:0]           addr_reg;
	logic [AW-1:0]           addr_next;
	logic                    rw_reg;
	logic                    rw_next;
	logic                    sda_oe_n_reg;
	logic                    sda_oe_n_next;
	logic                    sda_o_reg;
	logic                    sel_reg;
	logic                    sel_next;
	logic                    dev_match;
	logic                    byte_done;
	logic                    wdat_done;

	assign byte_done = scl_fall && (bitcnt_reg == sepfe_pkg::BIT_CNT_LAST);
	assign wdat_done = (state_reg == sepfe_pkg::ST_WDAT) && byte_done;

	// R4 address match
	// R5 both straps
	// R6 upper strap only
	// R7 lower ignored
	assign dev_match = (shift_reg[7:4] == DEV_TYPE) && (shift_reg[3] == strap_high_s)
		&& (LARGE || (shift_reg[2] == strap_low_s));

	// R1 write blocked
	// R2 write allowed
	assign mif.we    = wdat_done && !wp_s;
	assign mif.waddr = addr_reg;
	assign mif.wdata = shift_reg;
	assign mif.raddr = addr_reg;

	always_comb begin
		state_next    = state_reg;
		bitcnt_next   = bitcnt_reg;
		shift_next    = shift_reg;
		out_next      = out_reg;
		addr_next     = addr_reg;
		rw_next       = rw_reg;
		sda_oe_n_next = sda_oe_n_reg;
		sel_next      = sel_reg;
		// R8 sample on rise
		if (scl_rise && state_reg != sepfe_pkg::ST_IDLE) begin
			shift_next  = {shift_reg[6:0], sda_s};
			bitcnt_next = bitcnt_reg + 4'h1;
		end
		if (start_det) begin
			state_next    = sepfe_pkg::ST_DEV;
			bitcnt_next   = sepfe_pkg::BIT_CNT_RST;
			sda_oe_n_next = 1'b1;
			sel_next      = 1'b0;
		end else if (stop_det) begin
			state_next    = sepfe_pkg::ST_IDLE;
			sda_oe_n_next = 1'b1;
			sel_next      = 1'b0;
		end else if (scl_fall) begin
			// R9 change after fall
			case (state_reg)
				sepfe_pkg::ST_DEV: begin
					if (byte_done && dev_match) begin
						state_next    = sepfe_pkg::ST_DEV_ACK;
						rw_next       = shift_reg[0];
						sda_oe_n_next = 1'b0;
						sel_next      = 1'b1;
						if (!shift_reg[0]) begin
							addr_next[AW-1:8] = shift_reg[AW-8:1];
						end
					end else if (byte_done) begin
						state_next = sepfe_pkg::ST_IDLE;
					end
				end
				sepfe_pkg::ST_DEV_ACK: begin
					bitcnt_next = sepfe_pkg::BIT_CNT_RST;
					if (rw_reg) begin
						state_next    = sepfe_pkg::ST_RDAT;
						out_next      = mif.rdata;
						sda_oe_n_next = mif.rdata[7];
					end else begin
						state_next    = sepfe_pkg::ST_WORD;
						sda_oe_n_next = 1'b1;
					end
				end
				sepfe_pkg::ST_WORD: begin
					if (byte_done) begin
						state_next     = sepfe_pkg::ST_WORD_ACK;
						addr_next[7:0] = shift_reg;
						sda_oe_n_next  = 1'b0;
					end
				end
				sepfe_pkg::ST_WORD_ACK, sepfe_pkg::ST_WDAT_ACK: begin
					state_next    = sepfe_pkg::ST_WDAT;
					bitcnt_next   = sepfe_pkg::BIT_CNT_RST;
					sda_oe_n_next = 1'b1;
				end
				sepfe_pkg::ST_WDAT: begin
					if (byte_done) begin
						// The byte counter rolls inside its page, so a long burst rewrites the page start.
						state_next    = sepfe_pkg::ST_WDAT_ACK;
						addr_next[sepfe_pkg::PAGE_W-1:0] = addr_reg[sepfe_pkg::PAGE_W-1:0] + 1'b1;
						sda_oe_n_next = 1'b0;
					end
				end
				sepfe_pkg::ST_RDAT: begin
					if (byte_done) begin
						state_next    = sepfe_pkg::ST_RACK;
						addr_next     = addr_reg + 1'b1;
						sda_oe_n_next = 1'b1;
					end else begin
						out_next      = {out_reg[6:0], 1'b0};
						sda_oe_n_next = out_reg[6];
					end
				end
				sepfe_pkg::ST_RACK: begin
					bitcnt_next = sepfe_pkg::BIT_CNT_RST;
					// The host's acknowledge was taken into the shift register at the last rise.
					if (!shift_reg[0]) begin
						state_next    = sepfe_pkg::ST_RDAT;
						out_next      = mif.rdata;
						sda_oe_n_next = mif.rdata[7];
					end else begin
						state_next    = sepfe_pkg::ST_IDLE;
						sel_next      = 1'b0;
					end
				end
				default: begin
					state_next = sepfe_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg    <= sepfe_pkg::ST_IDLE;
			bitcnt_reg   <= sepfe_pkg::BIT_CNT_RST;
			shift_reg    <= sepfe_pkg::SHIFT_RST;
			out_reg      <= sepfe_pkg::SHIFT_RST;
			addr_reg     <= '0;
			rw_reg       <= 1'b0;
			sda_oe_n_reg <= sepfe_pkg::OE_N_RST;
			sda_o_reg    <= sepfe_pkg::SDA_LOW;
			sel_reg      <= 1'b0;
		end else begin
			state_reg    <= state_next;
			bitcnt_reg   <= bitcnt_next;
			shift_reg    <= shift_next;
			out_reg      <= out_next;
			addr_reg     <= addr_next;
			rw_reg       <= rw_next;
			sda_oe_n_reg <= sda_oe_n_next;
			// R10 open drain
			sda_o_reg    <= sepfe_pkg::SDA_LOW;
			sel_reg      <= sel_next;
		end
	end

	assign sda_o    = sda_o_reg;
	assign sda_oe_n = sda_oe_n_reg;
	assign selected = sel_reg;

	sepfe_mem #(.DEPTH(DEPTH)) u_mem (
		.clk (clk),
		.mif (mif)
	);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence dev_byte_matched;
		state_reg == sepfe_pkg::ST_DEV && byte_done && dev_match && !start_det && !stop_det;
	endsequence

	sequence ack_driven;
		state_reg == sepfe_pkg::ST_DEV_ACK && !sda_oe_n_reg;
	endsequence

	wp_block_a: assert property (wdat_done && wp_s |-> !mif.we) // R1
		else $error("array write while protected");

	wp_pass_a: assert property (wdat_done && !wp_s |-> mif.we) // R2
		else $error("array write lost while unprotected");

	dev_ack_a: assert property (dev_byte_matched |=> ack_driven) // R4
		else $error("matched address not acknowledged");

	no_match_a: assert property (state_reg == sepfe_pkg::ST_DEV && byte_done && !dev_match
		&& !start_det && !stop_det |=> state_reg == sepfe_pkg::ST_IDLE && sda_oe_n_reg) // R4
		else $error("unmatched address not ignored");

	strap_low_a: assert property ($rose(sel_reg) |-> LARGE || $past(shift_reg[2]) == strap_low_s) // R5
		else $error("lower strap mismatch selected device");

	strap_high_a: assert property ($rose(sel_reg) |-> $past(shift_reg[3]) == strap_high_s) // R6
		else $error("upper strap mismatch selected device");

	sample_rise_a: assert property (bitcnt_reg != $past(bitcnt_reg) && bitcnt_reg != 4'h0
		|-> $past(scl_rise)) // R8
		else $error("bit counted without clock rise");

	sda_change_a: assert property (sda_oe_n_reg != $past(sda_oe_n_reg)
		|-> $past(scl_fall) || $past(start_det) || $past(stop_det)) // R9
		else $error("data output changed outside clock fall");

	sda_level_a: assert property (sda_o_reg == 1'b0 [*2]) // R10
		else $error("data line driven high");

endmodule : sepfe_top

// ### design/sepfe_pkg.sv
// Shared constants and types for the serial memory pin front end.
package sepfe_pkg;

	localparam int          DATA_W       = 8;
	localparam int          DEPTH_SMALL  = 512;
	localparam int          DEPTH_LARGE  = 1024;
	localparam int          PAGE_W       = 4;
	localparam int          BITS_PER_BYTE = 8;
	localparam logic [3:0]  BIT_CNT_RST  = 4'h0;
	localparam logic [3:0]  BIT_CNT_LAST = 4'h8;
	localparam logic [7:0]  SHIFT_RST    = 8'h00;
	localparam logic        OE_N_RST     = 1'b1;
	localparam logic        SDA_LOW      = 1'b0;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_DEV      = 4'h1,
		ST_DEV_ACK  = 4'h3,
		ST_WORD     = 4'h2,
		ST_WORD_ACK = 4'h6,
		ST_WDAT     = 4'h7,
		ST_WDAT_ACK = 4'h5,
		ST_RDAT     = 4'h4,
		ST_RACK     = 4'hC
	} sepfe_state_e;

endpackage : sepfe_pkg

// ### design/sepfe_mem_if.sv
// Port bundle between the protocol engine and the byte array.
`timescale 1ns/1ps
interface sepfe_mem_if #(parameter int AW = 9);
	logic          we;
	logic [AW-1:0] waddr;
	logic [7:0]    wdata;
	logic [AW-1:0] raddr;
	logic [7:0]    rdata;

	modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
	modport array (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : sepfe_mem_if

// ### design/sepfe_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module sepfe_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : sepfe_sync

// ### design/sepfe_mem.sv
// Byte-wide storage array held in flip-flops.
`timescale 1ns/1ps
module sepfe_mem #(
	parameter int DEPTH = sepfe_pkg::DEPTH_SMALL
) (
	// Clock
	input  wire logic clk,
	// Access port
	sepfe_mem_if.array mif
);
	logic [sepfe_pkg::DATA_W-1:0] cell_reg [DEPTH];

	// Contents are not cleared by reset, as in a non-volatile part.
	always_ff @(posedge clk) begin
		if (mif.we) begin
			cell_reg[mif.waddr] <= mif.wdata;
		end
	end

	assign mif.rdata = cell_reg[mif.raddr];
endmodule : sepfe_mem

// ### testbench/sepfe_host.sv
// Behavioural two-wire bus host that drives the serial clock and data.
`timescale 1ns/1ps
module sepfe_host (
	// Clock
	input  wire logic clk,
	// Bus
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	int n_unstable;
	initial begin
		scl = 1'h1;
		sda_pull = 1'h0;
		n_unstable = 0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic bit_io(input logic b, output logic s);
		tick(2);
		sda_pull <= ~b;
		tick(2);
		scl <= 1'h1;
		tick(2);
		s = sda;
		tick(2);
		if (sda !== s) n_unstable++;
		scl <= 1'h0;
	endtask : bit_io
	task automatic start_c();
		tick(2);
		sda_pull <= 1'h0;
		tick(2);
		scl <= 1'h1;
		tick(4);
		sda_pull <= 1'h1;
		tick(4);
		scl <= 1'h0;
	endtask : start_c
	task automatic stop_c();
		tick(2);
		sda_pull <= 1'h1;
		tick(2);
		scl <= 1'h1;
		tick(4);
		sda_pull <= 1'h0;
		tick(4);
	endtask : stop_c
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'h1, ack);
	endtask : send_byte
	task automatic recv_byte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, s);
			b[i] = s;
		end
		bit_io(ack, s);
	endtask : recv_byte
endmodule : sepfe_host

// ### testbench/tb.sv
// Bench with one host and both memory sizes sharing one bus.
`timescale 1ns/1ps
module tb;
	logic clk, srst, wp, s_lo, s_hi, b_lo, b_hi, scl, pull, sda;
	logic o_s, oe_n_s, sel_s, o_b, oe_n_b, sel_b;
	int   errors, n_compared, cycles;
	// pull-up bus, clients may only pull low.
	assign sda = ~pull & (oe_n_s | o_s) & (oe_n_b | o_b);
	sepfe_top #(.DEPTH(512), .DEV_TYPE(4'hA)) u_sepfe_top (.clk(clk), .srst(srst), .scl_pin(scl),
		.sda_in(sda), .sda_o(o_s), .sda_oe_n(oe_n_s), .wp_pin(wp), .chip_select_strap_low(s_lo),
		.chip_select_strap_high(s_hi), .selected(sel_s));
	sepfe_top #(.DEPTH(1024), .DEV_TYPE(4'h5)) u_sepfe_top_big (.clk(clk), .srst(srst), .scl_pin(scl),
		.sda_in(sda), .sda_o(o_b), .sda_oe_n(oe_n_b), .wp_pin(wp), .chip_select_strap_low(b_lo),
		.chip_select_strap_high(b_hi), .selected(sel_b));
	sepfe_host u_sepfe_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
	////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	function automatic logic [7:0] dev_byte(input logic big, a2, a1, input logic [9:0] ad, input logic rd);
		return big ? {4'h5, a2, ad[9:8], rd} : {4'hA, a2, a1, ad[8], rd};
	endfunction : dev_byte
	task automatic mem_wr(input logic big, a2, a1, input logic [9:0] ad, input logic [7:0] d);
		logic ack;
		u_sepfe_host.start_c();
		u_sepfe_host.send_byte(dev_byte(big, a2, a1, ad, 1'h0), ack);
		u_sepfe_host.send_byte(ad[7:0], ack);
		u_sepfe_host.send_byte(d, ack);
		check("data ack", ack, 8'h00);
		u_sepfe_host.stop_c();
	endtask : mem_wr
	task automatic mem_rd(input logic big, a2, a1, input logic [9:0] ad, output logic [7:0] d);
		logic ack;
		u_sepfe_host.start_c();
		u_sepfe_host.send_byte(dev_byte(big, a2, a1, ad, 1'h0), ack);
		u_sepfe_host.send_byte(ad[7:0], ack);
		u_sepfe_host.start_c();
		u_sepfe_host.send_byte(dev_byte(big, a2, a1, ad, 1'h1), ack);
		u_sepfe_host.recv_byte(1'h1, d);
		u_sepfe_host.stop_c();
	endtask : mem_rd
	task automatic probe(input logic big, a2, a1, exp);
		logic ack;
		u_sepfe_host.start_c();
		u_sepfe_host.send_byte(dev_byte(big, a2, a1, 10'h000, 1'h0), ack);
		check("select ack", ack, exp);
		check("selected", big ? sel_b : sel_s, {7'h00, ~exp});
		u_sepfe_host.stop_c();
	endtask : probe
	// both ends of the small array.
	task automatic t_write_read();
		logic [7:0] d;
		mem_wr(1'h0, 1'h1, 1'h0, 10'h1FF, 8'h5A);
		mem_wr(1'h0, 1'h1, 1'h0, 10'h000, 8'hA5);
		mem_rd(1'h0, 1'h1, 1'h0, 10'h1FF, d);
		check("rd 1FF", d, 8'h5A);
		mem_rd(1'h0, 1'h1, 1'h0, 10'h000, d);
		check("rd 000", d, 8'hA5);
	endtask : t_write_read
	task automatic t_protect();
		logic [7:0] d;
		wp <= 1'h1;
		mem_wr(1'h0, 1'h1, 1'h0, 10'h1FF, 8'h3C);
		wp <= 1'h0;
		mem_rd(1'h0, 1'h1, 1'h0, 10'h1FF, d);
		check("rd protected", d, 8'h5A);
	endtask : t_protect
	// two-byte page write, then a two-byte sequential read with a host acknowledge.
	task automatic t_burst();
		logic       ack;
		logic [7:0] d;
		u_sepfe_host.start_c();
		u_sepfe_host.send_byte(dev_byte(1'h0, 1'h1, 1'h0, 10'h020, 1'h0), ack);
		u_sepfe_host.send_byte(8'h20, ack);
		u_sepfe_host.send_byte(8'h11, ack);
		u_sepfe_host.send_byte(8'h22, ack);
		check("burst ack", ack, 8'h00);
		u_sepfe_host.stop_c();
		u_sepfe_host.start_c();
		u_sepfe_host.send_byte(dev_byte(1'h0, 1'h1, 1'h0, 10'h020, 1'h0), ack);
		u_sepfe_host.send_byte(8'h20, ack);
		u_sepfe_host.start_c();
		u_sepfe_host.send_byte(dev_byte(1'h0, 1'h1, 1'h0, 10'h020, 1'h1), ack);
		u_sepfe_host.recv_byte(1'h0, d);
		check("burst rd 0", d, 8'h11);
		u_sepfe_host.recv_byte(1'h1, d);
		check("burst rd 1", d, 8'h22);
		u_sepfe_host.stop_c();
	endtask : t_burst
	task automatic t_strap();
		for (int i = 0; i < 4; i++) probe(1'h0, i[1], i[0], i != 2);
	endtask : t_strap
	task automatic t_float();
		logic [7:0] d;
		s_lo <= 1'hz;
		s_hi <= 1'hz;
		wp <= 1'hz;
		probe(1'h0, 1'h0, 1'h0, 1'h0);
		probe(1'h0, 1'h1, 1'h0, 1'h1);
		mem_wr(1'h0, 1'h0, 1'h0, 10'h010, 8'h77);
		mem_rd(1'h0, 1'h0, 1'h0, 10'h010, d);
		check("rd open wp", d, 8'h77);
	endtask : t_float
	// large part uses the upper strap only.
	task automatic t_big();
		logic [7:0] d;
		for (int i = 0; i < 2; i++) begin
			b_lo <= i[0];
			probe(1'h1, 1'h1, 1'h0, 1'h0);
			probe(1'h1, 1'h0, 1'h0, 1'h1);
		end
		mem_wr(1'h1, 1'h1, 1'h0, 10'h3FF, 8'hC3);
		mem_rd(1'h1, 1'h1, 1'h0, 10'h3FF, d);
		check("rd 3FF", d, 8'hC3);
	endtask : t_big
	////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (srst === 1'h0 && (oe_n_s & oe_n_b) === 1'h0) check("drive level", o_s | o_b, 8'h00);
		if (cycles == 40000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		{srst, wp, s_lo, s_hi, b_lo, b_hi} = 6'h25;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		srst <= 1'h0;
		repeat (4) @(posedge clk);
		t_write_read();
		t_protect();
		t_burst();
		t_strap();
		t_float();
		t_big();
		check("stable high", u_sepfe_host.n_unstable != 0, 8'h00);
		report_and_stop();
	end
endmodule : tb
